// *** verilog/cpm_top.sv ***
`timescale 1ns/1ns
`include "cpm_regs.svh"
module cpm_top #(
   parameter int LOCK_PULSE_CYC = `CPM_LOCK_PULSE_CYC
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // avalon-mm slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // three-wire programming port
   input  wire logic        prog_clk,
   input  wire logic        serial_prog_data,
   input  wire logic        prog_strobe,
   // bidirectional data pin
   input  wire logic        radio_data_pin_in,
   output logic             radio_data_pin_out,
   output logic             radio_data_pin_oe,
   // radio core side
   input  wire logic        demod_bit,
   input  wire logic        synth_locked,
   output logic             fsk_upper,
   output logic             tx_enable,
   output logic             rx_enable,
   output logic             power_down,
   output logic             xosc_keep_on,
   output cpm_pkg::cpm_if_type if_select,
   // lock indicator pin
   output logic             lock_pin
);
   import cpm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////

   function automatic logic [7:0] be_mask(input logic [3:0] be, input logic [1:0] lane);
      be_mask = {8{be[lane]}};
   endfunction

   function automatic logic is_cfg(input logic [7:0] addr);
      is_cfg = (addr[7:5] == 3'(`CPM_CFG_BASE >> 5));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [5:0] pins_s;

   cpm_sync #(
      .WIDTH (6)
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({synth_locked, demod_bit, radio_data_pin_in,
                  prog_strobe, serial_prog_data, prog_clk}),
      .sync_out (pins_s)
   );

   logic sclk_s;
   logic sdata_s;
   logic strobe_s;
   logic pin_in_s;
   logic demod_s;
   logic lock_s;

   assign sclk_s   = pins_s[0];
   assign sdata_s  = pins_s[1];
   assign strobe_s = pins_s[2];
   assign pin_in_s = pins_s[3];
   assign demod_s  = pins_s[4];
   assign lock_s   = pins_s[5];

   ////////////////////////////////////////////////////////////////////////////
   // serial frame receiver

   logic                       ctrl_ser_en;
   logic                       frame_valid;
   logic                       len_err;
   logic [`CPM_FRAME_BITS-1:0] frame;
   logic [5:0]                 bit_cnt;

   cpm_shift #(
      .FRAME_BITS (`CPM_FRAME_BITS)
   ) u_shift (
      .clk         (clk),
      .rst_n       (rst_n),
      .sclk_s      (sclk_s),
      .sdata_s     (sdata_s),
      .strobe_s    (strobe_s),
      .enable      (ctrl_ser_en),
      .frame_valid (frame_valid),
      .len_err     (len_err),
      .frame       (frame),
      .bit_cnt     (bit_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // configuration words

   // only rst_n (supply loss) clears them; power-down leaves them alone
   logic [`CPM_DATA_BITS-1:0] cfg [`CPM_NUM_WORDS];
   logic [`CPM_NUM_WORDS-1:0] written;
   logic [2:0]                last_addr;
   logic [2:0]                frame_addr;

   assign frame_addr = frame[`CPM_ADDR_MSB:`CPM_ADDR_LSB];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < `CPM_NUM_WORDS; i++) begin
            cfg[i] <= `CPM_CFG_RESET;
         end
         written   <= '0;
         last_addr <= 3'h0;
      end else if (frame_valid) begin
         // a single frame updates one word; the others stay as loaded
         cfg[frame_addr]     <= frame[`CPM_DATA_BITS-1:0];
         written[frame_addr] <= 1'b1;
         last_addr           <= frame_addr;
      end
   end

   logic [`CPM_DATA_BITS-1:0] mode_word;
   logic                      cfg_tx;
   logic                      cfg_pd;
   logic                      cfg_loside;
   logic [1:0]                cfg_lock;
   logic [1:0]                cfg_if;

   assign mode_word  = cfg[`CPM_MODE_WORD];
   assign cfg_tx     = mode_word[`CPM_TX_BIT];
   assign cfg_pd     = mode_word[`CPM_PD_BIT];
   assign cfg_loside = mode_word[`CPM_LOSIDE_BIT];
   assign cfg_lock   = mode_word[`CPM_LOCK_LSB +: 2];
   assign cfg_if     = mode_word[`CPM_IF_LSB +: 2];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_enable    <= 1'b0;
         rx_enable    <= 1'b0;
         power_down   <= 1'b0;
         xosc_keep_on <= 1'b0;
         if_select    <= CPM_IF_60K;
      end else begin
         tx_enable    <= !cfg_pd && cfg_tx;
         rx_enable    <= !cfg_pd && !cfg_tx;
         power_down   <= cfg_pd;
         xosc_keep_on <= mode_word[`CPM_XOSC_BIT];
         // the unused code falls back to the on-chip 60 kHz filter
         unique case (cfg_if)
            2'h1:    if_select <= CPM_IF_200K;
            2'h2:    if_select <= CPM_IF_455K;
            default: if_select <= CPM_IF_60K;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data pin

   // receive data is only resynchronised and inverted when cfg_loside is set, never filtered or qualified
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         radio_data_pin_out <= 1'b0;
         radio_data_pin_oe  <= 1'b0;
         fsk_upper          <= 1'b0;
      end else if (cfg_pd) begin
         radio_data_pin_out <= 1'b0;
         radio_data_pin_oe  <= 1'b0;
         fsk_upper          <= 1'b0;
      end else if (cfg_tx) begin
         radio_data_pin_out <= 1'b0;
         radio_data_pin_oe  <= 1'b0;
         // sampled far above the 9.6 kbit/s stream, so no edge is lost
         fsk_upper          <= pin_in_s;
      end else begin
         radio_data_pin_out <= demod_s ^ cfg_loside;
         radio_data_pin_oe  <= 1'b1;
         fsk_upper          <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // lock indicator

   logic        lock_d;
   logic [15:0] pulse_cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_d <= 1'b0;
      end else begin
         lock_d <= lock_s;
      end
   end

   // one-shot: a pulse each time lock is gained, LOCK_PULSE_CYC cycles long or until lock is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt <= 16'h0000;
      end else if (cfg_lock != CPM_LOCK_ONE || cfg_pd || !lock_s) begin
         pulse_cnt <= 16'h0000;
      end else if (lock_s && !lock_d) begin
         pulse_cnt <= 16'(LOCK_PULSE_CYC);
      end else if (pulse_cnt != 16'h0000) begin
         pulse_cnt <= pulse_cnt - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_pin <= 1'b0;
      end else if (cfg_pd) begin
         lock_pin <= 1'b0;
      end else begin
         unique case (cfg_lock)
            CPM_LOCK_CONT: lock_pin <= lock_s;
            CPM_LOCK_ONE:  lock_pin <= (pulse_cnt != 16'h0000);
            default:       lock_pin <= 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, answer on the second edge

   logic access;
   logic wr_now;
   logic rd_now;

   assign access = (avs_read || avs_write) && avs_waitrequest;
   assign wr_now = avs_write && !avs_waitrequest;
   assign rd_now = avs_read && !avs_waitrequest;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !access;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ser_en <= `CPM_CTRL_RESET;
      end else if (wr_now && avs_address == `CPM_CTRL_ADDR && avs_byteenable[0]) begin
         ctrl_ser_en <= avs_writedata[`CPM_CTRL_SER_EN];
      end
   end

   // sticky frame flags, write one to clear; a new event wins over the clear
   logic       st_len_err;
   logic       st_done;
   logic [7:0] clr;

   assign clr = (wr_now && avs_address == `CPM_STAT_ADDR)
                ? (avs_writedata[7:0] & be_mask(avs_byteenable, 2'h0)) : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_len_err <= 1'b0;
         st_done    <= 1'b0;
      end else begin
         st_len_err <= len_err || (st_len_err && !clr[`CPM_ST_LEN_ERR]);
         st_done    <= frame_valid || (st_done && !clr[`CPM_ST_DONE]);
      end
   end

   logic [15:0] frame_count;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_count <= 16'h0000;
      end else if (frame_valid) begin
         frame_count <= frame_count + 16'h0001;
      end
   end

   logic [31:0] status;

   always_comb begin
      status                          = 32'h0000_0000;
      status[`CPM_ST_LOCK]            = lock_s;
      status[`CPM_ST_TX]              = cfg_tx;
      status[`CPM_ST_PD]              = cfg_pd;
      status[`CPM_ST_LEN_ERR]         = st_len_err;
      status[`CPM_ST_DONE]            = st_done;
      status[`CPM_ST_ADDR_LSB +: 3]   = last_addr;
      status[`CPM_ST_CNT_LSB +: 4]    = bit_cnt[3:0];
      status[`CPM_ST_MASK_LSB +: 8]   = written;
   end

   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (is_cfg(avs_address)) begin
         rd_mux = {19'h00000, cfg[avs_address[4:2]]};
      end else if (avs_address == `CPM_CTRL_ADDR) begin
         rd_mux = {31'h0000_0000, ctrl_ser_en};
      end else if (avs_address == `CPM_STAT_ADDR) begin
         rd_mux = status;
      end else if (avs_address == `CPM_FCNT_ADDR) begin
         rd_mux = {16'h0000, frame_count};
      end
   end

   // data is loaded on the edge that drops waitrequest, so it stands with it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (access && avs_read) begin
         avs_readdata <= rd_mux;
      end else if (rd_now) begin
         avs_readdata <= avs_readdata;
      end
   end

endmodule

// *** verilog/cpm_regs.svh ***
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH

// bus map, byte addresses
`define CPM_CFG_BASE      8'h00
`define CPM_CTRL_ADDR     8'h20
`define CPM_STAT_ADDR     8'h24
`define CPM_FCNT_ADDR     8'h28

// serial frame layout
`define CPM_FRAME_BITS    16
`define CPM_ADDR_MSB      15
`define CPM_ADDR_LSB      13
`define CPM_DATA_BITS     13
`define CPM_NUM_WORDS     8

// mode word, configuration index 0
`define CPM_MODE_WORD     3'h0
`define CPM_TX_BIT        0
`define CPM_PD_BIT        1
`define CPM_XOSC_BIT      2
`define CPM_IF_LSB        3
`define CPM_LOSIDE_BIT    5
`define CPM_LOCK_LSB      6
`define CPM_CFG_RESET     13'h0000

// control register
`define CPM_CTRL_SER_EN   0
`define CPM_CTRL_RESET    1'h1

// status register
`define CPM_ST_LOCK       0
`define CPM_ST_TX         1
`define CPM_ST_PD         2
`define CPM_ST_LEN_ERR    3
`define CPM_ST_DONE       4
`define CPM_ST_ADDR_LSB   8
`define CPM_ST_CNT_LSB    12
`define CPM_ST_MASK_LSB   16

// timing
`define CPM_CLK_PERIOD_NS 8
`define CPM_LOCK_PULSE_NS 1000
`define CPM_LOCK_PULSE_CYC ((`CPM_LOCK_PULSE_NS + `CPM_CLK_PERIOD_NS - 1) / `CPM_CLK_PERIOD_NS)

`endif

// *** verilog/cpm_pkg.sv ***
package cpm_pkg;

   typedef enum logic [1:0] {
      CPM_IDLE  = 2'h0,
      CPM_SHIFT = 2'h1,
      CPM_LOAD  = 2'h3
   } cpm_state_type;

   typedef enum logic [1:0] {
      CPM_IF_60K  = 2'h0,
      CPM_IF_200K = 2'h1,
      CPM_IF_455K = 2'h2
   } cpm_if_type;

   typedef enum logic [1:0] {
      CPM_LOCK_OFF  = 2'h0,
      CPM_LOCK_CONT = 2'h1,
      CPM_LOCK_ONE  = 2'h2
   } cpm_lock_mode_type;

endpackage

// *** verilog/cpm_sync.sv ***
`timescale 1ns/1ns
module cpm_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // asynchronous levels in, synchronised levels out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta     <= '0;
         sync_out <= '0;
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule

// *** verilog/cpm_shift.sv ***
`timescale 1ns/1ns
`include "cpm_regs.svh"
module cpm_shift #(
   parameter int FRAME_BITS = `CPM_FRAME_BITS
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // synchronised serial lines
   input  wire logic                  sclk_s,
   input  wire logic                  sdata_s,
   input  wire logic                  strobe_s,
   input  wire logic                  enable,
   // frame out
   output logic                       frame_valid,
   output logic                       len_err,
   output logic [FRAME_BITS-1:0]      frame,
   output logic [5:0]                 bit_cnt
);
   import cpm_pkg::*;

   cpm_state_type   state;
   logic            sclk_d;
   logic            strobe_d;
   logic            fall;
   logic            strobe_rise;
   logic            strobe_fall;

   assign fall        = sclk_d & ~sclk_s;
   assign strobe_rise = strobe_s & ~strobe_d;
   assign strobe_fall = strobe_d & ~strobe_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d   <= 1'b0;
         strobe_d <= 1'b0;
      end else begin
         sclk_d   <= sclk_s;
         strobe_d <= strobe_s;
      end
   end

   // data sampled on the falling serial clock, msb first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state       <= CPM_IDLE;
         frame       <= '0;
         bit_cnt     <= 6'h00;
         frame_valid <= 1'b0;
         len_err     <= 1'b0;
      end else begin
         frame_valid <= 1'b0;
         len_err     <= 1'b0;
         unique case (state)
            CPM_IDLE, CPM_SHIFT: begin
               if (strobe_rise) begin
                  state <= CPM_LOAD;
               end else if (fall && !strobe_s && enable) begin
                  state   <= CPM_SHIFT;
                  frame   <= {frame[FRAME_BITS-2:0], sdata_s};
                  bit_cnt <= (bit_cnt == 6'h3f) ? bit_cnt : bit_cnt + 6'h01;
               end
            end
            CPM_LOAD: begin
               // commit on the strobe fall; short or long frames are dropped
               if (strobe_fall) begin
                  state   <= CPM_IDLE;
                  bit_cnt <= 6'h00;
                  if (bit_cnt == 6'(FRAME_BITS)) begin
                     frame_valid <= 1'b1;
                  end else begin
                     len_err <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

endmodule

// *** verif/cpm_mcu_model.sv ***
`timescale 1ns/1ns
module cpm_mcu_model (
   // programming port
   output logic prog_clk,
   output logic serial_prog_data,
   output logic prog_strobe,
   // level offered to the data pin, level seen on it
   output logic tx_level,
   input  logic rx_level
);
   initial begin
      prog_clk = 1'b1;
      serial_prog_data = 1'b0;
      prog_strobe = 1'b0;
      tx_level = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // clock idles high between frames; extra clocks land while the strobe is high
   task automatic send_frame(input logic [15:0] f, input int n, input int extra);
      for (int i = 15; i > 15 - n; i--) begin
         serial_prog_data = f[i];
         #62 prog_clk = 1'b0;
         #63 prog_clk = 1'b1;
      end
      // released data line must not look like the last bit
      serial_prog_data = !serial_prog_data;
      #62 prog_strobe = 1'b1;
      for (int i = 0; i < extra; i++) begin
         #62 prog_clk = 1'b0;
         #63 prog_clk = 1'b1;
      end
      #62 prog_strobe = 1'b0;
      #125;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // half bit of 128 ns: far above the real rate, keeps the run short
   task automatic send_manchester(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         tx_level = b[i];
         #128 tx_level = !tx_level;
         #128;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // raw pin level: eight samples per half bit, majority decides
   task automatic sample_half(output logic b);
      logic [3:0] ones;
      ones = 4'h0;
      for (int i = 0; i < 8; i++) begin
         #16 ones = ones + 4'(rx_level);
      end
      b = (ones > 4'h4);
   endtask
endmodule

// *** verif/cpm_top_chk.sv ***
`timescale 1ns/1ns
module cpm_top_chk (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // bus
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // programming strobe
   input wire logic        prog_strobe,
   // data pin and radio core
   input wire logic        radio_data_pin_in,
   input wire logic        radio_data_pin_out,
   input wire logic        radio_data_pin_oe,
   input wire logic        demod_bit,
   input wire logic        synth_locked,
   input wire logic        fsk_upper,
   input wire logic        tx_enable,
   input wire logic        rx_enable,
   input cpm_pkg::cpm_if_type if_select,
   input wire logic        lock_pin
);
   import cpm_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered after one wait cycle");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low longer than one cycle");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h28
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_tx_high: assert property ((tx_enable && radio_data_pin_in)[*5] |-> fsk_upper)
      else $error("high pin did not select upper frequency");
   a_tx_low: assert property ((tx_enable && !radio_data_pin_in)[*5] |-> !fsk_upper)
      else $error("low pin did not select lower frequency");
   a_tx_release: assert property (tx_enable[*4] |-> !radio_data_pin_oe)
      else $error("pin driven in transmit mode");
   a_rx_drive: assert property (rx_enable[*4] |-> radio_data_pin_oe)
      else $error("pin not driven in receive mode");
   // a committed mode word may flip the polarity, so a strobe edge masks the window
   a_rx_steady: assert property ((rx_enable && $stable(demod_bit)
      && $stable(prog_strobe))[*8] |-> $stable(radio_data_pin_out))
      else $error("rx pin moved with steady demod");
   a_lock_lost: assert property ((!synth_locked)[*6] |-> !lock_pin)
      else $error("lock shown without lock");
   a_mode_excl: assert property (!(tx_enable && rx_enable))
      else $error("transmit and receive both enabled");
   a_if_legal: assert property (if_select != 2'h3)
      else $error("illegal if selection");
   c_tx_upper: cover property (tx_enable && fsk_upper);
   c_lock_rise: cover property ($rose(lock_pin));
   c_rx_one: cover property (radio_data_pin_oe && radio_data_pin_out);
endmodule
bind cpm_top cpm_top_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .prog_strobe(prog_strobe),
   .radio_data_pin_in(radio_data_pin_in),
   .radio_data_pin_out(radio_data_pin_out), .radio_data_pin_oe(radio_data_pin_oe),
   .demod_bit(demod_bit), .synth_locked(synth_locked), .fsk_upper(fsk_upper),
   .tx_enable(tx_enable), .rx_enable(rx_enable), .if_select(if_select), .lock_pin(lock_pin));

// *** verif/cpm_top_tb_top.sv ***
`timescale 1ns/1ns
module cpm_top_tb_top;
   import cpm_pkg::*;
   localparam int         LOCK_CYC = 4;
   localparam logic [12:0] MODE_RX = 13'h0068;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  avs_address = 8'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        prog_clk, serial_prog_data, prog_strobe, tx_level;
   logic        radio_data_pin_out, radio_data_pin_oe, radio_data_pin_in;
   logic        demod_bit = 1'b0;
   logic        synth_locked = 1'b0;
   logic        fsk_upper, tx_enable, rx_enable, power_down, xosc_keep_on, lock_pin;
   cpm_if_type  if_select;
   int          failures = 0;
   int          checks_done = 0;
   always #4 clk = ~clk;
   // wire level: the device wins while it drives, else the controller
   assign radio_data_pin_in = radio_data_pin_oe ? radio_data_pin_out : tx_level;
   cpm_top #(.LOCK_PULSE_CYC(LOCK_CYC)) uut (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .prog_clk(prog_clk),
      .serial_prog_data(serial_prog_data), .prog_strobe(prog_strobe),
      .radio_data_pin_in(radio_data_pin_in), .radio_data_pin_out(radio_data_pin_out),
      .radio_data_pin_oe(radio_data_pin_oe), .demod_bit(demod_bit),
      .synth_locked(synth_locked), .fsk_upper(fsk_upper), .tx_enable(tx_enable),
      .rx_enable(rx_enable), .power_down(power_down), .xosc_keep_on(xosc_keep_on),
      .if_select(if_select), .lock_pin(lock_pin));
   cpm_mcu_model mcu (.prog_clk(prog_clk), .serial_prog_data(serial_prog_data),
      .prog_strobe(prog_strobe), .tx_level(tx_level), .rx_level(radio_data_pin_in));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      if (n >= 20) chk(1'b0, 1'b1, "bus hang");
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e, m);
   endtask
   function automatic logic [12:0] wval(int i);
      return {i[2:0], 10'h0a3} ^ 13'h1555;
   endfunction
   task automatic frame(input logic [2:0] a, input logic [12:0] d);
      mcu.send_frame({a, d}, 16, 0);
   endtask
   // off the edge so sampled outputs have settled
   task automatic settle;
      repeat (6) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk({rx_enable, radio_data_pin_oe}, 2'h3, "receive after reset");
      chk({tx_enable, power_down, lock_pin}, 3'h0, "outputs after reset");
      for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0, "word reset");
      rd(8'h20, 32'h1, "ctrl reset");
      rd(8'h3c, 32'h0, "unmapped read");
   endtask
   task automatic t_full;
      frame(3'h0, MODE_RX);
      for (int i = 1; i < 8; i++) frame(3'(i), wval(i));
      settle();
      rd(8'h00, {19'h0, MODE_RX}, "mode word");
      for (int i = 1; i < 8; i++) rd(8'(4 * i), {19'h0, wval(i)}, "word");
      rd(8'h28, 32'h8, "frame count");
      chk(if_select, CPM_IF_200K, "if select");
   endtask
   task automatic t_rx;
      logic b;
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         demod_bit <= v[0];
         settle();
         chk(radio_data_pin_out, !v[0], "rx level inverted");
         mcu.sample_half(b);
         chk(b, !v[0], "oversampled rx");
      end
      @(posedge clk);
      synth_locked <= 1'b1;
      settle();
      chk(lock_pin, 1'b1, "continuous lock");
      @(posedge clk);
      synth_locked <= 1'b0;
      settle();
      chk(lock_pin, 1'b0, "lock lost");
   endtask
   task automatic t_strobe;
      logic [31:0] q;
      mcu.send_frame({3'h7, 13'h0f0f}, 16, 3);
      mcu.send_frame({3'h6, 13'h1111}, 15, 0);
      settle();
      rd(8'h1c, 32'h0f0f, "clocks under strobe");
      rd(8'h18, {19'h0, wval(6)}, "short frame");
      bus(1'b0, 8'h24, 32'h0, q);
      chk(q[3], 1'b1, "length flag");
      bus(1'b1, 8'h24, 32'h8, q);
      bus(1'b1, 8'h04, 32'h0, q);
      bus(1'b0, 8'h24, 32'h0, q);
      chk(q[3], 1'b0, "length flag cleared");
      rd(8'h04, {19'h0, wval(1)}, "word read only");
      bus(1'b1, 8'h20, 32'h0, q);
      rd(8'h20, 32'h0, "serial port off");
      frame(3'h5, 13'h0000);
      settle();
      rd(8'h14, {19'h0, wval(5)}, "frame while disabled");
      bus(1'b1, 8'h20, 32'h1, q);
   endtask
   task automatic t_tx;
      frame(3'h0, MODE_RX | 13'h1);
      settle();
      chk({tx_enable, rx_enable, radio_data_pin_oe}, 3'h4, "tx mode");
      fork
         mcu.send_manchester(8'ha6);
         for (int k = 0; k < 16; k++) begin
            #60;
            chk(fsk_upper, radio_data_pin_in, "keying");
            #68;
         end
      join
   endtask
   task automatic t_pd;
      frame(3'h0, MODE_RX | 13'h6);
      settle();
      chk({power_down, xosc_keep_on, radio_data_pin_oe}, 3'h6, "power down");
      for (int i = 1; i < 7; i++) rd(8'(4 * i), {19'h0, wval(i)}, "kept");
      for (int c = 0; c < 4; c++) begin
         frame(3'h0, 13'h0060 | 13'(c << 3));
         settle();
         chk(if_select, (c == 3) ? 0 : c, "if code");
      end
   endtask
   task automatic t_lock;
      int n;
      n = 0;
      frame(3'h0, 13'h00a8);
      settle();
      @(posedge clk);
      synth_locked <= 1'b1;
      repeat (30) begin
         @(posedge clk);
         if (lock_pin === 1'b1) n++;
      end
      chk(n, LOCK_CYC, "one-shot width");
      frame(3'h0, 13'h0028);
      settle();
      chk(lock_pin, 1'b0, "lock detect off");
      @(posedge clk);
      synth_locked <= 1'b0;
   endtask
   task automatic t_loss;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      rd(8'h04, 32'h0, "supply loss");
      chk(rx_enable, 1'b1, "receive again");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      t_reset();
      t_full();
      t_rx();
      t_strobe();
      t_tx();
      t_pd();
      t_lock();
      t_loss();
      test_done();
   end
   initial begin
      #500000;
      failures++;
      test_done();
   end
endmodule
